// ### design/oirx_pkg.sv
package oirx_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] IRQ_EVENT_SET_OFF      = 8'ha0;
    localparam logic [7:0] IRQ_EVENT_CLEAR_OFF    = 8'ha4;
    localparam logic [7:0] IRQ_MASK_SET_OFF       = 8'ha8;
    localparam logic [7:0] IRQ_MASK_CLEAR_OFF     = 8'hac;
    localparam logic [7:0] INITIAL_BANDWIDTH_OFF  = 8'hb0;
    localparam logic [7:0] INITIAL_CHAN_UPPER_OFF = 8'hb4;
    localparam logic [7:0] INITIAL_CHAN_LOWER_OFF = 8'hb8;
    localparam logic [7:0] FAIRNESS_CONTROL_OFF   = 8'hdc;

    // ------------------------------------------------------------
    // Field widths and reset values
    // ------------------------------------------------------------
    localparam int          CHANNELS         = 4;
    localparam int          BANDWIDTH_WIDTH  = 13;
    localparam int          PRI_REQ_WIDTH    = 8;
    localparam logic [12:0] BANDWIDTH_RESET  = 13'h1333;
    localparam logic [31:0] CHANNELS_RESET   = 32'hffff_ffff;
    localparam logic [7:0]  PRI_REQ_RESET    = 8'h00;
    localparam logic [3:0]  MASK_RESET       = 4'h0;
    localparam logic [3:0]  EVENT_RESET      = 4'h0;

    // Load sequencer states for the CSR copy
    typedef enum logic [1:0] {
        OIRX_LOAD_IDLE,
        OIRX_LOAD_COPY
    } oirx_load_e;

endpackage : oirx_pkg

// ### design/oirx_edge_detect.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// Rising edge detector for channel interrupt lines
// ------------------------------------------------------------
module oirx_edge_detect
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] level,
    output logic      [3:0] rise
);

    typedef struct packed {
        logic [3:0] last;
        logic [3:0] rise;
    } oirx_edge_s;

    oirx_edge_s state;
    oirx_edge_s next_state;

    always_comb
    begin
        next_state      = state;
        next_state.last = level;
        next_state.rise = level & ~state.last;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rise = state.rise;

endmodule : oirx_edge_detect

// ### design/oirx_regs.sv
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

// Overview of operation
// - Per-channel receive interrupt mask, reached at set and clear addresses.
// - Reads at mask set or clear address return the mask itself.
// - Mask bit n enables event bit n, one per receive channel.
// - Event bits set on channel rising edge or set write; clear by clear write.
// - Thirteen-bit bandwidth field resets to 1333h, survives bus reset.
// - Any listed reset copies bandwidth field into bandwidth CSR.
// - Bandwidth register bits above field read zero, writes ignored.
// - Upper and lower channel fields 32 bits, reset all ones, survive bus reset.
// - Listed resets copy upper channel field into upper channels CSR.
// - Listed resets copy lower channel field into lower channels CSR.
// - Fairness register lets software allow several requests per interval.
// - Low eight fairness bits limit priority requests per interval, default zero.
module oirx_regs
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic [3:0]  channel_irq,
    input  wire logic        global_reset_input,
    input  wire logic        link_reset_input,
    input  wire logic        legacy_bus_reset_input,
    input  wire logic        bus_reset_input,
    output logic             iso_receive_interrupt,
    output logic [3:0]       iso_rx_flags,
    output logic [12:0]      bandwidth_available_csr,
    output logic [31:0]      channels_available_upper_csr,
    output logic [31:0]      channels_available_lower_csr,
    output logic             csr_load_strobe,
    output logic [7:0]       pri_req_limit
);

    typedef struct packed {
        logic [3:0]                mask;
        logic [3:0]                events;
        logic [12:0]               initial_bandwidth_field;
        logic [31:0]               initial_channels_upper_field;
        logic [31:0]               initial_channels_lower_field;
        logic [7:0]                pri_req;
        logic [12:0]               bw_csr;
        logic [31:0]               chan_hi_csr;
        logic [31:0]               chan_lo_csr;
        logic                      load;
        logic                      irq;
        logic [31:0]               rdata;
        oirx_pkg::oirx_load_e      load_state;
    } oirx_regs_s;

    oirx_regs_s state;
    oirx_regs_s next_state;
    logic [3:0] channel_rise;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    oirx_edge_detect u_edge
    (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (channel_irq),
        .rise    (channel_rise)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic       any_reset;
        logic [3:0] ev_set;
        logic [3:0] ev_clr;
        any_reset  = 1'b0;
        ev_set     = 4'h0;
        ev_clr     = 4'h0;
        next_state = state;
        next_state.rdata = 32'h0000_0000;
        next_state.load  = 1'b0;

        // Register writes
        if (wr)
        begin
            if (hit(addr, oirx_pkg::IRQ_MASK_SET_OFF))
            begin
                next_state.mask = state.mask | wdata[3:0];
            end
            if (hit(addr, oirx_pkg::IRQ_MASK_CLEAR_OFF))
            begin
                next_state.mask = state.mask & ~wdata[3:0];
            end
            if (hit(addr, oirx_pkg::IRQ_EVENT_SET_OFF))
            begin
                ev_set = wdata[3:0];
            end
            if (hit(addr, oirx_pkg::IRQ_EVENT_CLEAR_OFF))
            begin
                ev_clr = wdata[3:0];
            end
            if (hit(addr, oirx_pkg::INITIAL_BANDWIDTH_OFF))
            begin
                next_state.initial_bandwidth_field = wdata[12:0];
            end
            if (hit(addr, oirx_pkg::INITIAL_CHAN_UPPER_OFF))
            begin
                next_state.initial_channels_upper_field = wdata;
            end
            if (hit(addr, oirx_pkg::INITIAL_CHAN_LOWER_OFF))
            begin
                next_state.initial_channels_lower_field = wdata;
            end
            if (hit(addr, oirx_pkg::FAIRNESS_CONTROL_OFF))
            begin
                next_state.pri_req = wdata[7:0];
            end
        end

        // Event bits: set wins over clear
        next_state.events = (state.events & ~ev_clr) | ev_set | channel_rise;
        next_state.irq    = |(next_state.events & next_state.mask);

        // Register reads
        if (rd)
        begin
            case (addr)
                oirx_pkg::IRQ_EVENT_SET_OFF:
                    next_state.rdata = {28'h000_0000, state.events};
                oirx_pkg::IRQ_EVENT_CLEAR_OFF:
                    next_state.rdata = {28'h000_0000, state.events & state.mask};
                oirx_pkg::IRQ_MASK_SET_OFF,
                oirx_pkg::IRQ_MASK_CLEAR_OFF:
                    next_state.rdata = {28'h000_0000, state.mask};
                oirx_pkg::INITIAL_BANDWIDTH_OFF:
                    next_state.rdata = {19'h0_0000, state.initial_bandwidth_field};
                oirx_pkg::INITIAL_CHAN_UPPER_OFF:
                    next_state.rdata = state.initial_channels_upper_field;
                oirx_pkg::INITIAL_CHAN_LOWER_OFF:
                    next_state.rdata = state.initial_channels_lower_field;
                oirx_pkg::FAIRNESS_CONTROL_OFF:
                    next_state.rdata = {24'h00_0000, state.pri_req};
                default:
                    next_state.rdata = 32'h0000_0000;
            endcase
        end

        // Bus-management CSR load on any of the reset events
        any_reset = global_reset_input | link_reset_input
                  | legacy_bus_reset_input | bus_reset_input;
        case (state.load_state)
            oirx_pkg::OIRX_LOAD_IDLE:
            begin
                if (any_reset)
                begin
                    next_state.load_state = oirx_pkg::OIRX_LOAD_COPY;
                end
            end
            oirx_pkg::OIRX_LOAD_COPY:
            begin
                next_state.bw_csr      = state.initial_bandwidth_field;
                next_state.chan_hi_csr = state.initial_channels_upper_field;
                next_state.chan_lo_csr = state.initial_channels_lower_field;
                next_state.load        = 1'b1;
                next_state.load_state  = any_reset ? oirx_pkg::OIRX_LOAD_COPY
                                                   : oirx_pkg::OIRX_LOAD_IDLE;
            end
            default:
            begin
                next_state.load_state = oirx_pkg::OIRX_LOAD_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            state.mask                         <= oirx_pkg::MASK_RESET;
            state.events                       <= oirx_pkg::EVENT_RESET;
            state.initial_bandwidth_field      <= oirx_pkg::BANDWIDTH_RESET;
            state.initial_channels_upper_field <= oirx_pkg::CHANNELS_RESET;
            state.initial_channels_lower_field <= oirx_pkg::CHANNELS_RESET;
            state.pri_req                      <= oirx_pkg::PRI_REQ_RESET;
            state.bw_csr                       <= oirx_pkg::BANDWIDTH_RESET;
            state.chan_hi_csr                  <= oirx_pkg::CHANNELS_RESET;
            state.chan_lo_csr                  <= oirx_pkg::CHANNELS_RESET;
            state.load                         <= 1'b0;
            state.irq                          <= 1'b0;
            state.rdata                        <= 32'h0000_0000;
            state.load_state                   <= oirx_pkg::OIRX_LOAD_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign rdata                        = state.rdata;
    assign iso_receive_interrupt        = state.irq;
    assign iso_rx_flags                 = state.events;
    assign bandwidth_available_csr      = state.bw_csr;
    assign channels_available_upper_csr = state.chan_hi_csr;
    assign channels_available_lower_csr = state.chan_lo_csr;
    assign csr_load_strobe              = state.load;
    assign pri_req_limit                = state.pri_req;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    mask_set_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == oirx_pkg::IRQ_MASK_SET_OFF |=> ((state.mask & $past(wdata[3:0]))
        == $past(wdata[3:0])))
        else $error("Mask set write lost");

    mask_clear_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == oirx_pkg::IRQ_MASK_CLEAR_OFF |=> ((state.mask & $past(wdata[3:0]))
        == 4'h0))
        else $error("Mask clear write lost");

    mask_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd && (addr == oirx_pkg::IRQ_MASK_SET_OFF || addr == oirx_pkg::IRQ_MASK_CLEAR_OFF)
        |=> rdata == {28'h000_0000, $past(state.mask)})
        else $error("Mask read wrong");

    event_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(channel_irq[0]) |=> ##1 state.events[0])
        else $error("Channel edge missed");

    irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        iso_receive_interrupt == |(iso_rx_flags & state.mask))
        else $error("Interrupt does not match enabled events");

    bw_read_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd && addr == oirx_pkg::INITIAL_BANDWIDTH_OFF |=> rdata[31:13] == 19'h0_0000)
        else $error("Bandwidth upper bits not zero");

    csr_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus_reset_input && !wr |=> ##1 bandwidth_available_csr
        == $past(state.initial_bandwidth_field, 2))
        else $error("Bandwidth CSR not loaded");

    chan_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
        global_reset_input && !wr |=> ##1 (channels_available_upper_csr
        == $past(state.initial_channels_upper_field, 2)) && csr_load_strobe)
        else $error("Channel CSR not loaded");

    chan_lo_copy_a: assert property (@(posedge clk) disable iff (!reset_n)
        legacy_bus_reset_input && !wr |=> ##1 (channels_available_lower_csr
        == $past(state.initial_channels_lower_field, 2)))
        else $error("Lower channel CSR not loaded");

    load_source_a: assert property (@(posedge clk) disable iff (!reset_n)
        csr_load_strobe |-> $past(state.load_state == oirx_pkg::OIRX_LOAD_COPY))
        else $error("Load strobe without copy state");

    event_set_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == oirx_pkg::IRQ_EVENT_SET_OFF |=> ((state.events & $past(wdata[3:0]))
        == $past(wdata[3:0])))
        else $error("Event set write lost");

    event_clear_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == oirx_pkg::IRQ_EVENT_CLEAR_OFF && channel_rise == 4'h0
        |=> ((state.events & $past(wdata[3:0])) == 4'h0))
        else $error("Event clear write lost");

    event_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(wr && addr == oirx_pkg::IRQ_EVENT_CLEAR_OFF)
        |=> ((state.events & $past(state.events)) == $past(state.events)))
        else $error("Event bit dropped without clear write");

    mask_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !(wr && (addr == oirx_pkg::IRQ_MASK_SET_OFF || addr == oirx_pkg::IRQ_MASK_CLEAR_OFF))
        |=> state.mask == $past(state.mask))
        else $error("Mask changed without mask write");

    bw_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr && addr == oirx_pkg::INITIAL_BANDWIDTH_OFF
        |=> state.initial_bandwidth_field == $past(wdata[12:0]))
        else $error("Bandwidth field write lost");

    bw_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus_reset_input && !wr
        |=> state.initial_bandwidth_field == $past(state.initial_bandwidth_field))
        else $error("Bandwidth field disturbed by bus reset");

    chan_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus_reset_input && !wr
        |=> state.initial_channels_lower_field == $past(state.initial_channels_lower_field))
        else $error("Channel field disturbed by bus reset");

    fair_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        rd && addr == oirx_pkg::FAIRNESS_CONTROL_OFF
        |=> rdata == {24'h00_0000, $past(state.pri_req)})
        else $error("Fairness read wrong");

endmodule : oirx_regs

// ### testbench/oirx_regs_tb_top.sv
`timescale 1ns/100ps

module oirx_regs_tb_top;
    logic        clk         = 1'b0;
    logic        reset_n     = 1'b0;
    logic [7:0]  addr        = 8'h00;
    logic [31:0] wdata       = 32'h0000_0000;
    logic        wr          = 1'b0;
    logic        rd          = 1'b0;
    logic [3:0]  channel_irq = 4'h0;
    logic [3:0]  rst_in      = 4'h0;
    logic [31:0] rdata;
    logic        irq_out;
    logic [3:0]  flags;
    logic [12:0] bw_csr;
    logic [31:0] up_csr;
    logic [31:0] lo_csr;
    logic        load_strobe;
    logic [7:0]  pri_req;
    int          bad_count   = 0;
    int          cmp_count   = 0;
    int          cycles      = 0;

    always #10 clk = ~clk;

    oirx_regs dut
    (
        .clk                          (clk),
        .reset_n                      (reset_n),
        .addr                         (addr),
        .wdata                        (wdata),
        .wr                           (wr),
        .rd                           (rd),
        .rdata                        (rdata),
        .channel_irq                  (channel_irq),
        .global_reset_input           (rst_in[0]),
        .link_reset_input             (rst_in[1]),
        .legacy_bus_reset_input       (rst_in[2]),
        .bus_reset_input              (rst_in[3]),
        .iso_receive_interrupt        (irq_out),
        .iso_rx_flags                 (flags),
        .bandwidth_available_csr      (bw_csr),
        .channels_available_upper_csr (up_csr),
        .channels_available_lower_csr (lo_csr),
        .csr_load_strobe              (load_strobe),
        .pri_req_limit                (pri_req)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : bus_write

    task automatic expect_read(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(name, rdata, exp);
    endtask : expect_read

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic test_reset_values();
        expect_read("mask_set", oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0000);
        expect_read("bandwidth", oirx_pkg::INITIAL_BANDWIDTH_OFF, 32'h0000_1333);
        expect_read("chan_upper", oirx_pkg::INITIAL_CHAN_UPPER_OFF, 32'hffff_ffff);
        expect_read("chan_lower", oirx_pkg::INITIAL_CHAN_LOWER_OFF, 32'hffff_ffff);
        expect_read("fairness", oirx_pkg::FAIRNESS_CONTROL_OFF, 32'h0000_0000);
        check("pri_req_out", {24'h00_0000, pri_req}, 32'h0000_0000);
        expect_read("unmapped", 8'he0, 32'h0000_0000);
    endtask : test_reset_values

    task automatic test_mask();
        bus_write(oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0005);
        bus_write(oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0000);
        expect_read("mask_at_clear", oirx_pkg::IRQ_MASK_CLEAR_OFF, 32'h0000_0005);
        bus_write(oirx_pkg::IRQ_MASK_CLEAR_OFF, 32'h0000_0004);
        bus_write(oirx_pkg::IRQ_MASK_CLEAR_OFF, 32'h0000_0000);
        expect_read("mask_after_clr", oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0001);
        bus_write(oirx_pkg::IRQ_MASK_SET_OFF, 32'hffff_fff0);
        expect_read("mask_upper", oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0001);
    endtask : test_mask

    task automatic test_events();
        @(posedge clk);
        channel_irq <= 4'h2;
        settle(3);
        check("flags_edge", {28'h0, flags}, 32'h0000_0002);
        check("irq_masked", {31'h0, irq_out}, 32'h0000_0000);
        expect_read("event_and_mask", oirx_pkg::IRQ_EVENT_CLEAR_OFF, 32'h0000_0000);
        bus_write(oirx_pkg::IRQ_MASK_SET_OFF, 32'h0000_0002);
        settle(2);
        check("irq_enabled", {31'h0, irq_out}, 32'h0000_0001);
        expect_read("event_and_mask2", oirx_pkg::IRQ_EVENT_CLEAR_OFF, 32'h0000_0002);
        bus_write(oirx_pkg::IRQ_EVENT_CLEAR_OFF, 32'h0000_0002);
        settle(2);
        check("flags_cleared", {28'h0, flags}, 32'h0000_0000);
        check("irq_cleared", {31'h0, irq_out}, 32'h0000_0000);
        bus_write(oirx_pkg::IRQ_EVENT_SET_OFF, 32'h0000_0008);
        expect_read("event_set", oirx_pkg::IRQ_EVENT_SET_OFF, 32'h0000_0008);
        bus_write(oirx_pkg::IRQ_EVENT_CLEAR_OFF, 32'h0000_000f);
        channel_irq <= 4'h1;
        settle(3);
        check("flags_ch0", {28'h0, flags}, 32'h0000_0001);
        check("irq_ch0", {31'h0, irq_out}, 32'h0000_0001);
        bus_write(oirx_pkg::IRQ_EVENT_CLEAR_OFF, 32'h0000_0001);
        channel_irq <= 4'h0;
        settle(2);
        check("flags_final", {28'h0, flags}, 32'h0000_0000);
    endtask : test_events

    task automatic test_loads();
        bus_write(oirx_pkg::INITIAL_BANDWIDTH_OFF, 32'hffff_ffff);
        expect_read("bw_upper_bits", oirx_pkg::INITIAL_BANDWIDTH_OFF, 32'h0000_1fff);
        for (int i = 0; i < 4; i++)
        begin
            bus_write(oirx_pkg::INITIAL_BANDWIDTH_OFF, 32'h0000_0100 + i);
            bus_write(oirx_pkg::INITIAL_CHAN_UPPER_OFF, 32'h1234_0000 + i);
            bus_write(oirx_pkg::INITIAL_CHAN_LOWER_OFF, 32'h0000_5678 + i);
            rst_in <= 4'h1 << i;
            @(posedge clk);
            rst_in <= 4'h0;
            settle(1);
            check("load_strobe", {31'h0, load_strobe}, 32'h0000_0001);
            check("bw_csr", {19'h0, bw_csr}, 32'h0000_0100 + i);
            check("upper_csr", up_csr, 32'h1234_0000 + i);
            check("lower_csr", lo_csr, 32'h0000_5678 + i);
            settle(1);
            check("load_drop", {31'h0, load_strobe}, 32'h0000_0000);
        end
        expect_read("bw_kept", oirx_pkg::INITIAL_BANDWIDTH_OFF, 32'h0000_0103);
        expect_read("upper_kept", oirx_pkg::INITIAL_CHAN_UPPER_OFF, 32'h1234_0003);
        expect_read("lower_kept", oirx_pkg::INITIAL_CHAN_LOWER_OFF, 32'h0000_5678 + 3);
    endtask : test_loads

    task automatic test_fairness();
        bus_write(oirx_pkg::FAIRNESS_CONTROL_OFF, 32'h0000_01a5);
        expect_read("fairness_rw", oirx_pkg::FAIRNESS_CONTROL_OFF, 32'h0000_00a5);
        check("pri_req_out", {24'h00_0000, pri_req}, 32'h0000_00a5);
    endtask : test_fairness

    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        test_reset_values();
        test_mask();
        test_events();
        test_loads();
        test_fairness();
        final_report();
    end
endmodule : oirx_regs_tb_top
